// ===== test/act_link_asserts.sv
// checker on the link between the host end and the master device end.
// assumes linkClk from the host and the devices' reset on arst_n.
`timescale 1ns/1ps
module act_link_asserts
(
	// clock and reset
	input  wire logic linkClk,
	input  wire logic arst_n,
	// link
	input  wire logic ctlSel_n,
	input  wire logic tdmBclkOe,
	input  wire logic tdmFsOe,
	input  wire logic tdmBclk,
	input  wire logic tdmFs,
	input  wire logic tdmToHost
);
	// ==========================================
	// helper counters
	logic [4:0]  selCnt_r;
	logic [12:0] frmCnt_r;
	logic        frmSeen_r;
	logic        fsPrev_r;
	default clocking cb @(posedge linkClk); endclocking
	default disable iff (!arst_n);
	// select low time, judged when select is released
	always_ff @(posedge linkClk or negedge arst_n)
		if (!arst_n)
			selCnt_r <= 5'h00;
		else if (ctlSel_n)
			selCnt_r <= 5'h00;
		else
			selCnt_r <= selCnt_r + 5'h01;
	// frame spacing; the first start only arms the count
	always_ff @(posedge linkClk or negedge arst_n)
		if (!arst_n)
		begin
			frmCnt_r  <= 13'h0000;
			frmSeen_r <= 1'b0;
			fsPrev_r  <= 1'b0;
		end
		else
		begin
			fsPrev_r <= tdmFs;
			frmCnt_r <= (tdmFs & ~fsPrev_r) ? 13'h0001 : frmCnt_r + 13'h0001;
			if (tdmFs & ~fsPrev_r)
				frmSeen_r <= 1'b1;
		end
	// ==========================================
	// properties
	a_sel_len: assert property ($rose(ctlSel_n) |-> selCnt_r == 5'h10)
		else $error("select low time wrong");
	a_sel_hold: assert property ($fell(ctlSel_n) |-> !ctlSel_n [*8])
		else $error("select released early");
	a_oe_pair: assert property (tdmBclkOe == tdmFsOe)
		else $error("clock and sync drive differ");
	a_bclk: assert property ($rose(tdmBclk) |-> tdmBclk [*4] ##1 !tdmBclk [*4])
		else $error("bit clock shape wrong");
	a_fs_width: assert property ($rose(tdmFs) |-> tdmFs [*8] ##1 !tdmFs)
		else $error("frame sync width wrong");
	a_frame_len: assert property (tdmFs && !fsPrev_r && frmSeen_r |-> frmCnt_r == 13'h1000)
		else $error("frame length wrong");
	a_out_edge: assert property ($changed(tdmToHost) |-> !tdmBclk)
		else $error("data changed while bit clock high");
	a_idle: assert property (!tdmFsOe && !$past(tdmFsOe) |-> $stable(tdmToHost))
		else $error("chain moved outside cascade");
endmodule // act_link_asserts

// ===== test/test_adc_control_and_cascade_tdm.sv
// bench: host end and a master device end on one link; the bench is the
// slave stage on chainIn. assumes act_cfg.svh on the include path.
`timescale 1ns/1ps
`include "act_cfg.svh"
module test_adc_control_and_cascade_tdm
	import act_pkg::*;
;
	logic        mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        adcValid = 0, chainIn = 0, devRst_n, pready, pslverr, err;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, expQ[$];
	logic [23:0] adcLeft = 0, adcRight = 0, dacLeft, dacRight, mL, smpL, smpR;
	logic        dacValid, hpfEnable, adcPowerDown, rate96k, auxMaster;
	logic        auxInputEnable, coreClkTimesTwo, coreClkTwoThirds;
	logic [9:0]  d;
	int          failures = 0, nCompared = 0, cycles = 0, c, fc;
	// ==========================================
	// ends, link and checker
	act_link_if lnk ();
	act_host act_host_inst (.lnk(lnk), .mclk(mclk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .powerdownResetPin_n(devRst_n));
	act_device act_device_inst (.lnk(lnk), .arst_n(devRst_n), .masterSel_n(1'b0),
		.adcLeft(adcLeft), .adcRight(adcRight), .adcValid(adcValid), .chainIn(chainIn),
		.dacLeft(dacLeft), .dacRight(dacRight), .dacValid(dacValid), .hpfEnable(hpfEnable),
		.adcPowerDown(adcPowerDown), .rate96k(rate96k), .auxMaster(auxMaster),
		.auxInputEnable(auxInputEnable), .coreClkTimesTwo(coreClkTimesTwo),
		.coreClkTwoThirds(coreClkTwoThirds));
	act_link_asserts act_link_asserts_inst (.linkClk(lnk.linkClk), .arst_n(devRst_n),
		.ctlSel_n(lnk.ctlSel_n), .tdmBclkOe(lnk.tdmBclkOe), .tdmFsOe(lnk.tdmFsOe),
		.tdmBclk(lnk.tdmBclk), .tdmFs(lnk.tdmFs), .tdmToHost(lnk.tdmToHost));
	// ==========================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen, exp);
		nCompared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (failures == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one APB transfer; waits on pready, no fixed latency assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// control word, then poll busy until the whole word has been shifted out
	task automatic cmd(input logic [15:0] w);
		apb(1, `ACT_APB_CMD, {16'h0000, w});
		repeat (4) @(posedge mclk);
		do apb(0, `ACT_APB_STAT, 0); while (rd[0] !== 1'b0);
	endtask
	task automatic wreg(input logic [3:0] a, input logic [9:0] v);
		cmd({a, 2'b00, v});
	endtask
	task automatic rdreg(input logic [3:0] a);
		cmd({a, 12'h800});
		apb(0, `ACT_APB_CTLRD, 0);
	endtask
	// samples enter on the link clock; driven just as it rises
	task automatic adc(input logic [23:0] l, r);
		@(posedge lnk.linkClk);
		adcLeft <= l;
		adcRight <= r;
		adcValid <= 1;
		@(posedge lnk.linkClk);
		adcValid <= 0;
	endtask
	// ==========================================
	// clock, timeout, sequence
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			failures++;
			report_and_stop();
		end
	end
	initial
	begin
		c = $urandom(31);
		repeat (3) @(posedge mclk);
		arst_n <= 1;
		apb(0, 8'h10, 0);
		check("unmapped", err, 1);
		apb(1, `ACT_APB_CTRL, 1);
		check("ctrl", err, 0);
		repeat (12) @(posedge mclk);
		check("device reset line", devRst_n, 1);
		rdreg(`ACT_ADDR_CTL1);
		check("ctl1 reset", rd[9:0], 10'h000);
		rdreg(`ACT_ADDR_PEAK_L);
		check("peak reset", rd[9:0], 10'h3F0);
		for (int i = 0; i < 4; i++)
		begin
			d = 10'($urandom);
			wreg(`ACT_ADDR_CTL1, d);
			rdreg(`ACT_ADDR_CTL1);
			check("ctl1", rd[9:0], d & 10'h1C0);
			check("ctl1 pins", {hpfEnable, adcPowerDown, rate96k}, d[8:6]);
		end
		for (int i = 0; i < 8; i++)
		begin
			d = 10'($urandom & 32'h23F) | 10'(i << 6);
			wreg(`ACT_ADDR_CTL2, d);
			rdreg(`ACT_ADDR_CTL2);
			check("ctl2", rd[9:0], d & 10'h3FB);
			check("ctl2 pins", {auxMaster, auxInputEnable}, {d[9], d[3]});
		end
		for (int i = 0; i < 4; i++)
		begin
			d = 10'($urandom & 32'h33F) | 10'(i << 6);
			wreg(`ACT_ADDR_CTL3, d);
			rdreg(`ACT_ADDR_CTL3);
			check("ctl3", rd[9:0], d & 10'h0E0);
			check("scale", {coreClkTimesTwo, coreClkTwoThirds}, {i == 0 || i == 3, i == 2});
		end
		// a loud sample leaves a level; a read clears it again
		wreg(`ACT_ADDR_CTL1, 10'h000);
		wreg(`ACT_ADDR_CTL3, 10'h060);
		adc(24'h7FFFFF, 24'h7FFFFF);
		rdreg(`ACT_ADDR_PEAK_L);
		check("peak kept", rd[9:0], 10'h000);
		rdreg(`ACT_ADDR_PEAK_L);
		check("peak cleared", rd[9:0], 10'h3F0);
		// cascade: format forced, master drives clocks, chain runs
		apb(1, `ACT_APB_CTRL, 3);
		d = 10'($urandom & 32'h20B) | 10'(($urandom % 3) << 4);
		wreg(`ACT_ADDR_CTL2, d);
		rdreg(`ACT_ADDR_CTL2);
		check("cascade format", rd[8:6], 3'h7);
		check("clock drive", {lnk.tdmBclkOe, lnk.tdmFsOe}, 2'h3);
		mL = d[5:4] == 2'h1 ? 24'hFFFFF0 : d[5:4] == 2'h2 ? 24'hFFFF00 : 24'hFFFFFF;
		c = $urandom % 2;
		chainIn <= c[0];
		smpL = 24'($urandom);
		smpR = 24'($urandom);
		adc(smpL, smpR);
		expQ.push_back(d[0] ? 32'h0 : {smpL & mL, 8'h00});
		expQ.push_back(d[1] ? 32'h0 : {smpR & mL, 8'h00});
		repeat (6) expQ.push_back(32'h0);
		repeat (8) expQ.push_back({32{c[0]}});
		apb(0, `ACT_APB_STAT, 0);
		fc = rd[31:16];
		do
		begin
			repeat (256) @(posedge mclk);
			apb(0, `ACT_APB_STAT, 0);
		end
		while (rd[31:16] < fc + 3);
		for (int k = 0; k < 16; k++)
		begin
			apb(0, 8'(8'h80 + 4 * k), 0);
			check("rx word", rd, expQ.pop_front());
		end
		do @(negedge lnk.linkClk); while (dacValid !== 1'b1);
		check("dac left", dacLeft, {24{c[0]}});
		check("dac right", dacRight, {24{c[0]}});
		report_and_stop();
	end
endmodule // test_adc_control_and_cascade_tdm

// ===== verilog/act_cfg.svh
// constants for the cascade codec link: control word layout, register
// addresses, field positions, frame sizes and the host's APB map.
// assumes nothing; included by the package and by the testbench.
`ifndef ACT_CFG_SVH
`define ACT_CFG_SVH
// ==========================================
// control word
`define ACT_WORD_BITS     16
`define ACT_ADDR_CTL1     4'hC
`define ACT_ADDR_CTL2     4'hD
`define ACT_ADDR_CTL3     4'hE
`define ACT_ADDR_PEAK_L   4'hA
`define ACT_ADDR_PEAK_R   4'hB
`define ACT_RESET_VAL     10'h000
// ==========================================
// register fields
`define ACT_MASK_CTL1     10'h1C0
`define ACT_MASK_CTL2     10'h3FB
`define ACT_MASK_CTL3     10'h0FF
`define ACT_MASK_CTL3_HOST 10'h0E0
`define ACT_BIT_HPF       8
`define ACT_BIT_PWDN      7
`define ACT_BIT_RATE      6
`define ACT_BIT_AUXMS     9
`define ACT_FMT_HI        8
`define ACT_FMT_LO        6
`define ACT_FMT_AUX512    3'h7
`define ACT_WID_HI        5
`define ACT_WID_LO        4
`define ACT_WID_20        2'h1
`define ACT_WID_16        2'h2
`define ACT_BIT_AUXEN     3
`define ACT_BIT_MUTE_R    1
`define ACT_BIT_MUTE_L    0
`define ACT_SCL_HI        7
`define ACT_SCL_LO        6
`define ACT_SCL_TWO_THIRD 2'h2
`define ACT_SCL_UNITY     2'h1
`define ACT_BIT_PEAKEN    5
`define ACT_PEAK_MAX      6'h3F
// ==========================================
// frame
`define ACT_LAST_BIT      9'h1FF
`define ACT_DIV_RISE      3'h3
`define ACT_DIV_FALL      3'h7
// ==========================================
// host APB map
`define ACT_APB_CTRL      8'h00
`define ACT_APB_CMD       8'h04
`define ACT_APB_STAT      8'h08
`define ACT_APB_CTLRD     8'h0C
`define ACT_APB_TX        2'h1
`define ACT_APB_RX        2'h2
`endif

// ===== verilog/act_device.sv
// codec device end: ADC control registers on the control port and one
// 256-bit stage of the cascade TDM shift chain.
// assumes linkClk is the shared master clock and arst_n the shared reset.
`timescale 1ns/1ps
// Notes on behaviour
// - control 1: filter, power-down, rate; rest zero
// - control 2 bits 8:6 select serial format
// - control 2: aux master, width, aux, mutes
// - control 3 bits 7:6 scale core clock
// - control 3 bit 5 enables peak tracking
// - controller keeps test fields at normal
// - controller sets both devices to aux 512 in cascade mode
// - strap low is master, high is slave
// - shared master clock and reset line
// - master drives frame sync and bit clock
// - each device is a 256-bit shift stage
// - frame start loads previous interval ADC results
// - master shifts out, takes slave's bits in
// - host shifts DAC data into slave
// - frame end hands DAC data onward
// - peak register clears after being read
// - rates assume scaled core clock setting
module act_device
	import act_pkg::*;
(
	// link
	act_link_if.device lnk,
	// reset and strap
	input  wire logic        arst_n,
	input  wire logic        masterSel_n,
	// converter samples
	input  wire logic [23:0] adcLeft,
	input  wire logic [23:0] adcRight,
	input  wire logic        adcValid,
	// chain input from the slave stage
	input  wire logic        chainIn,
	// DAC words
	output logic      [23:0] dacLeft,
	output logic      [23:0] dacRight,
	output logic             dacValid,
	// configuration
	output logic             hpfEnable,
	output logic             adcPowerDown,
	output logic             rate96k,
	output logic             auxMaster,
	output logic             auxInputEnable,
	output logic             coreClkTimesTwo,
	output logic             coreClkTwoThirds
);
	// ==========================================
	// registers
	act_reg_type ctl1_r;
	act_reg_type ctl2_r;
	act_reg_type ctl3_r;
	logic [5:0]  lvlL_r;
	logic [5:0]  lvlR_r;
	logic [2:0]  strapSync_r;
	logic        isSlave_r;
	logic [3:0]  ctlIdx_r;
	logic [14:0] ctlSh_r;
	act_reg_type ctlRd_r;
	logic        ctlDout_r;
	logic [15:0] word;
	logic        peakClrL;
	logic        peakClrR;
	logic        peakEn;
	logic [1:0]  width;

	// peak level as attenuation code, about 6 dB per leading bit
	function automatic logic [5:0] peakCode(input logic [23:0] s);
		logic [22:0] m;
		logic [5:0]  n;
		logic        hit;
		m = s[23] ? ~s[22:0] : s[22:0];
		n = 6'h00;
		hit = 1'b0;
		for (int i = 22; i >= 0; i--)
		begin
			if (m[i])
				hit = 1'b1;
			else if (!hit)
				n = n + 6'h01;
		end
		peakCode = (n > 6'h0A) ? `ACT_PEAK_MAX : 6'(n * 6'h06);
	endfunction

	// mute, power-down and word width shaping of a sample
	function automatic logic [23:0] shape(input logic [23:0] s, input logic mute);
		logic [23:0] v;
		v = (mute || ctl1_r[`ACT_BIT_PWDN]) ? 24'h000000 : s;
		if (width == `ACT_WID_20)
			v[3:0] = 4'h0;
		else if (width == `ACT_WID_16)
			v[7:0] = 8'h00;
		shape = v;
	endfunction

	assign width  = ctl2_r[`ACT_WID_HI:`ACT_WID_LO];
	assign peakEn = ctl3_r[`ACT_BIT_PEAKEN];

	// ==========================================
	// strap: three stages, role follows once the last two agree
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
			strapSync_r <= 3'h0;
		else
			strapSync_r <= {strapSync_r[1:0], masterSel_n};
	end

	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
			isSlave_r <= 1'b0;
		else if (strapSync_r[2] == strapSync_r[1])
			isSlave_r <= strapSync_r[2];
	end

	// ==========================================
	// control port: 16 bits msb first while ctlSel_n is low
	assign word = {ctlSh_r, lnk.ctlDin};
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctlIdx_r <= 4'h0;
			ctlSh_r  <= 15'h0000;
		end
		else if (lnk.ctlSel_n)
			ctlIdx_r <= 4'h0;
		else
		begin
			ctlIdx_r <= ctlIdx_r + 4'h1;
			ctlSh_r  <= word[14:0];
		end
	end

	// read value latched once address and rw are in, data out in slots 6..15
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctlRd_r   <= `ACT_RESET_VAL;
			ctlDout_r <= 1'b0;
		end
		else if (!lnk.ctlSel_n && ctlIdx_r == 4'h5)
		begin
			unique case (ctlSh_r[4:1])
				`ACT_ADDR_CTL1:   ctlRd_r <= ctl1_r;
				`ACT_ADDR_CTL2:   ctlRd_r <= ctl2_r;
				`ACT_ADDR_CTL3:   ctlRd_r <= ctl3_r;
				`ACT_ADDR_PEAK_L: ctlRd_r <= {~lvlL_r, 4'h0};
				`ACT_ADDR_PEAK_R: ctlRd_r <= {~lvlR_r, 4'h0};
				default:          ctlRd_r <= `ACT_RESET_VAL;
			endcase
		end
		else if (!lnk.ctlSel_n && ctlIdx_r > 4'h5)
			ctlDout_r <= ctlRd_r[4'hF - ctlIdx_r];
	end
	assign lnk.ctlDout = ctlDout_r;

	// register writes; reserved bits are forced to zero on the way in
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl1_r <= `ACT_RESET_VAL;
			ctl2_r <= `ACT_RESET_VAL;
			ctl3_r <= `ACT_RESET_VAL;
		end
		else if (!lnk.ctlSel_n && ctlIdx_r == 4'hF && !word[11])
		begin
			if (word[15:12] == `ACT_ADDR_CTL1)
				ctl1_r <= word[9:0] & `ACT_MASK_CTL1;
			if (word[15:12] == `ACT_ADDR_CTL2)
				ctl2_r <= word[9:0] & `ACT_MASK_CTL2;
			if (word[15:12] == `ACT_ADDR_CTL3)
				ctl3_r <= word[9:0] & `ACT_MASK_CTL3;
		end
	end

	// ==========================================
	// peak tracking, held as loudness so a clear is a plain zero
	assign peakClrL = !lnk.ctlSel_n && ctlIdx_r == 4'hF && word[11]
		&& word[15:12] == `ACT_ADDR_PEAK_L;
	assign peakClrR = !lnk.ctlSel_n && ctlIdx_r == 4'hF && word[11]
		&& word[15:12] == `ACT_ADDR_PEAK_R;

	// a sample arriving with the clear is kept: set wins
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lvlL_r <= 6'h00;
			lvlR_r <= 6'h00;
		end
		else
		begin
			if (adcValid && peakEn && (peakClrL || ~peakCode(adcLeft) > lvlL_r))
				lvlL_r <= ~peakCode(adcLeft);
			else if (peakClrL)
				lvlL_r <= 6'h00;
			if (adcValid && peakEn && (peakClrR || ~peakCode(adcRight) > lvlR_r))
				lvlR_r <= ~peakCode(adcRight);
			else if (peakClrR)
				lvlR_r <= 6'h00;
		end
	end

	// ==========================================
	// configuration outputs
	assign hpfEnable        = ctl1_r[`ACT_BIT_HPF];
	assign adcPowerDown     = ctl1_r[`ACT_BIT_PWDN];
	assign rate96k          = ctl1_r[`ACT_BIT_RATE];
	assign auxMaster        = ctl2_r[`ACT_BIT_AUXMS];
	assign auxInputEnable   = ctl2_r[`ACT_BIT_AUXEN];
	assign coreClkTwoThirds = ctl3_r[`ACT_SCL_HI:`ACT_SCL_LO] == `ACT_SCL_TWO_THIRD;
	assign coreClkTimesTwo  = !coreClkTwoThirds
		&& ctl3_r[`ACT_SCL_HI:`ACT_SCL_LO] != `ACT_SCL_UNITY;

	// ==========================================
	// cascade TDM stage
	logic        tdmOn;
	logic        drvEn_r;
	logic [2:0]  div_r;
	logic        bclk_r;
	logic        fs_r;
	logic [2:0]  bclkSync_r;
	logic [2:0]  fsSync_r;
	logic        bclkLvl_r;
	logic        riseEv;
	logic        fallEv;
	logic        inBit_r;
	logic [8:0]  bitCnt_r;
	logic [255:0] sr_r;
	logic [23:0] holdL_r;
	logic [23:0] holdR_r;

	// only the aux 512 format runs the chain
	assign tdmOn = ctl2_r[`ACT_FMT_HI:`ACT_FMT_LO] == `ACT_FMT_AUX512;

	// master bit clock is linkClk / 8, fs high for bit 0
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_r  <= 3'h0;
			bclk_r <= 1'b0;
		end
		else
		begin
			div_r <= div_r + 3'h1;
			if (div_r == `ACT_DIV_RISE)
				bclk_r <= 1'b1;
			else if (div_r == `ACT_DIV_FALL)
				bclk_r <= 1'b0;
		end
	end
	// drive and master timing switch only as the bit clock falls, so a format
	// change never puts a cut half period or a false edge on the pins
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
			drvEn_r <= 1'b0;
		else if (div_r == `ACT_DIV_FALL)
			drvEn_r <= tdmOn && !isSlave_r;
	end
	assign lnk.tdmBclkOut = bclk_r;
	assign lnk.tdmFsOut   = fs_r;
	assign lnk.tdmBclkOe  = drvEn_r;
	assign lnk.tdmFsOe    = drvEn_r;

	// slave follows the master's pins through three stages
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bclkSync_r <= 3'h0;
			fsSync_r   <= 3'h0;
			bclkLvl_r  <= 1'b0;
		end
		else
		begin
			bclkSync_r <= {bclkSync_r[1:0], lnk.tdmBclk};
			fsSync_r   <= {fsSync_r[1:0], lnk.tdmFs};
			if (bclkSync_r[2] == bclkSync_r[1])
				bclkLvl_r <= bclkSync_r[2];
		end
	end

	always_comb
	begin
		if (isSlave_r)
		begin
			riseEv = tdmOn && bclkSync_r[2] == bclkSync_r[1] && bclkSync_r[2] && !bclkLvl_r;
			fallEv = tdmOn && bclkSync_r[2] == bclkSync_r[1] && !bclkSync_r[2] && bclkLvl_r;
		end
		else
		begin
			riseEv = drvEn_r && div_r == `ACT_DIV_RISE;
			fallEv = drvEn_r && div_r == `ACT_DIV_FALL;
		end
	end

	// latest shaped samples wait for the next frame start
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			holdL_r <= 24'h000000;
			holdR_r <= 24'h000000;
		end
		else if (adcValid)
		begin
			holdL_r <= shape(adcLeft, ctl2_r[`ACT_BIT_MUTE_L]);
			holdR_r <= shape(adcRight, ctl2_r[`ACT_BIT_MUTE_R]);
		end
	end

	// sample on rising bit clock, shift and frame on falling
	always_ff @(posedge lnk.linkClk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			inBit_r  <= 1'b0;
			bitCnt_r <= 9'h000;
			fs_r     <= 1'b0;
			sr_r     <= '0;
			dacLeft  <= 24'h000000;
			dacRight <= 24'h000000;
			dacValid <= 1'b0;
		end
		else
		begin
			dacValid <= 1'b0;
			if (riseEv)
			begin
				// master takes the slave's bits, slave takes the host's
				inBit_r <= isSlave_r ? lnk.tdmFromHost : chainIn;
				if (isSlave_r && fsSync_r[2])
					bitCnt_r <= 9'h000;
			end
			if (fallEv)
			begin
				bitCnt_r <= bitCnt_r + 9'h001;
				fs_r     <= bitCnt_r == `ACT_LAST_BIT;
				if (bitCnt_r == `ACT_LAST_BIT)
				begin
					dacLeft  <= sr_r[254:231];
					dacRight <= sr_r[222:199];
					dacValid <= 1'b1;
					sr_r     <= {holdL_r, 8'h00, holdR_r, 8'h00, 192'h0};
				end
				else
					sr_r <= {sr_r[254:0], inBit_r};
			end
		end
	end
	assign lnk.tdmToHost = sr_r[255];
endmodule // act_device

// ===== verilog/act_host.sv
// controller end: APB slave with command, status and frame buffers, drives
// the control port and the host side of the cascade TDM chain.
// assumes mclk is the system clock; makes linkClk as mclk / 2.
`timescale 1ns/1ps
module act_host
	import act_pkg::*;
(
	// link
	act_link_if.host lnk,
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// shared device reset
	output logic             powerdownResetPin_n
);
	// ==========================================
	// registers
	logic [1:0]        ctrl_r;
	logic [15:0]       cmd_r;
	logic              startReq_r;
	act_ctl_state_type state_r;
	logic [4:0]        cnt_r;
	logic              linkClk_r;
	logic              sel_r;
	logic              din_r;
	act_reg_type       rd_r;
	logic [31:0]       txMem [16];
	logic [31:0]       rxMem [16];
	logic [15:0]       frames_r;
	logic              busy;
	logic              mapped;
	logic              wrEn;

	// clean a command: reserved and test bits zero, cascade forces aux 512
	function automatic logic [15:0] clean(input logic [15:0] w, input logic casc);
		act_reg_type d;
		d = w[9:0];
		if (w[15:12] == `ACT_ADDR_CTL1)
			d = d & `ACT_MASK_CTL1;
		if (w[15:12] == `ACT_ADDR_CTL2)
		begin
			d = d & `ACT_MASK_CTL2;
			if (casc)
				d[`ACT_FMT_HI:`ACT_FMT_LO] = `ACT_FMT_AUX512;
		end
		if (w[15:12] == `ACT_ADDR_CTL3)
			d = d & `ACT_MASK_CTL3_HOST;
		clean = {w[15:11], 1'b0, d};
	endfunction

	// ==========================================
	// APB: zero wait, read data set up in the setup cycle
	assign busy    = state_r != CTL_IDLE || startReq_r;
	assign mapped  = paddr[1:0] == 2'h0 && (paddr < 8'h10
		|| paddr[7:6] == `ACT_APB_TX || paddr[7:6] == `ACT_APB_RX);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wrEn    = psel && penable && pwrite && mapped;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h00000000;
		else if (psel && !penable)
		begin
			if (paddr[7:6] == `ACT_APB_TX)
				prdata <= txMem[paddr[5:2]];
			else if (paddr[7:6] == `ACT_APB_RX)
				prdata <= rxMem[paddr[5:2]];
			else if (paddr == `ACT_APB_CTRL)
				prdata <= {30'h0, ctrl_r};
			else if (paddr == `ACT_APB_CMD)
				prdata <= {16'h0, cmd_r};
			else if (paddr == `ACT_APB_STAT)
				prdata <= {frames_r, 15'h0, busy};
			else if (paddr == `ACT_APB_CTLRD)
				prdata <= {22'h0, rd_r};
			else
				prdata <= 32'h00000000;
		end
	end

	// control bits; bit 0 releases the shared reset line of both devices
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_r <= 2'h0;
		else if (wrEn && paddr == `ACT_APB_CTRL)
			ctrl_r <= pwdata[1:0];
	end
	assign powerdownResetPin_n = ctrl_r[0];

	always_ff @(posedge mclk)
	begin
		if (wrEn && paddr[7:6] == `ACT_APB_TX)
			txMem[paddr[5:2]] <= pwdata;
	end

	// ==========================================
	// control port: pins change and dout is sampled as linkClk falls
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			linkClk_r <= 1'b0;
		else
			linkClk_r <= !linkClk_r;
	end
	assign lnk.linkClk  = linkClk_r;
	assign lnk.ctlSel_n = !sel_r;
	assign lnk.ctlDin   = din_r;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd_r      <= 16'h0000;
			startReq_r <= 1'b0;
			state_r    <= CTL_IDLE;
			cnt_r      <= 5'h00;
			sel_r      <= 1'b0;
			din_r      <= 1'b0;
			rd_r       <= `ACT_RESET_VAL;
		end
		else
		begin
			// a command written while busy is dropped
			if (wrEn && paddr == `ACT_APB_CMD && !busy)
			begin
				cmd_r      <= clean(pwdata[15:0], ctrl_r[1]);
				startReq_r <= 1'b1;
			end
			if (linkClk_r)
			begin
				unique case (state_r)
					CTL_IDLE:
						if (startReq_r)
						begin
							startReq_r <= 1'b0;
							state_r    <= CTL_SHIFT;
							sel_r      <= 1'b1;
							din_r      <= cmd_r[15];
							cnt_r      <= 5'h01;
						end
					CTL_SHIFT:
					begin
						if (cnt_r > 5'h06)
							rd_r <= {rd_r[8:0], lnk.ctlDout};
						if (cnt_r == 5'h10)
						begin
							sel_r   <= 1'b0;
							din_r   <= 1'b0;
							state_r <= CTL_IDLE;
						end
						else
						begin
							din_r <= cmd_r[4'hF - cnt_r[3:0]];
							cnt_r <= cnt_r + 5'h01;
						end
					end
				endcase
			end
		end
	end

	// ==========================================
	// TDM: bit clock, frame sync and data through three stages
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic       bclkLvl_r;
	logic       rise;
	logic       fall;
	logic [8:0] bitIdx_r;
	logic [8:0] newIdx;
	logic [8:0] nxt;
	logic [31:0] rxSh_r;
	logic       dout_r;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_r      <= 3'h0;
			s2_r      <= 3'h0;
			s3_r      <= 3'h0;
			bclkLvl_r <= 1'b0;
		end
		else
		begin
			s1_r <= {lnk.tdmBclk, lnk.tdmFs, lnk.tdmToHost};
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r[2] == s3_r[2])
				bclkLvl_r <= s3_r[2];
		end
	end
	assign rise   = s2_r[2] == s3_r[2] && s3_r[2] && !bclkLvl_r;
	assign fall   = s2_r[2] == s3_r[2] && !s3_r[2] && bclkLvl_r;
	assign newIdx = s3_r[1] ? 9'h000 : bitIdx_r + 9'h001;
	assign nxt    = bitIdx_r + 9'h001;
	assign lnk.tdmFromHost = dout_r;

	// take ADC bits on rising, present DAC bits on falling
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bitIdx_r <= `ACT_LAST_BIT;
			rxSh_r   <= 32'h00000000;
			frames_r <= 16'h0000;
			dout_r   <= 1'b0;
		end
		else
		begin
			if (rise)
			begin
				bitIdx_r <= newIdx;
				rxSh_r   <= {rxSh_r[30:0], s3_r[0]};
				if (newIdx == `ACT_LAST_BIT)
					frames_r <= frames_r + 16'h0001;
			end
			if (fall)
				dout_r <= txMem[nxt[8:5]][5'h1F - nxt[4:0]];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rise && newIdx[4:0] == 5'h1F)
			rxMem[newIdx[8:5]] <= {rxSh_r[30:0], s3_r[0]};
	end
endmodule // act_host

// ===== verilog/act_link_if.sv
// link between the DSP-side controller and one codec device.
// the wires of the two-way clock pins are resolved here from the enables.
`timescale 1ns/1ps
interface act_link_if;
	logic linkClk;
	logic ctlSel_n;
	logic ctlDin;
	logic ctlDout;
	logic tdmBclkOut;
	logic tdmBclkOe;
	logic tdmFsOut;
	logic tdmFsOe;
	logic tdmBclk;
	logic tdmFs;
	logic tdmToHost;
	logic tdmFromHost;
	// undriven pins read low
	assign tdmBclk = tdmBclkOe & tdmBclkOut;
	assign tdmFs   = tdmFsOe & tdmFsOut;
	modport device (input linkClk, ctlSel_n, ctlDin, tdmBclk, tdmFs, tdmFromHost,
		output ctlDout, tdmBclkOut, tdmBclkOe, tdmFsOut, tdmFsOe, tdmToHost);
	modport host (output linkClk, ctlSel_n, ctlDin, tdmFromHost,
		input ctlDout, tdmBclk, tdmFs, tdmToHost);
endinterface // act_link_if

// ===== verilog/act_pkg.sv
// types shared by both ends of the cascade codec link.
// assumes act_cfg.svh is on the include path.
package act_pkg;
	`include "act_cfg.svh"
	typedef enum logic {CTL_IDLE, CTL_SHIFT} act_ctl_state_type;
	typedef logic [9:0] act_reg_type;
endpackage
